/* File: rtl/conn_ctrl.sv */
// connection controller for one serial port of a serial-to-network gateway
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
module conn_ctrl
    import conn_ctrl_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES,
    parameter int AW       = BUF_AW
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // serial side
    input  wire logic        ser_rx_valid,
    input  wire logic [7:0]  ser_rx_data,
    input  wire logic        ser_tx_valid,
    input  wire logic        cts_in,
    input  wire logic        dsr_in,
    // network side
    output logic             net_open_req,
    output logic             net_close_req,
    output logic             net_reset_req,
    input  wire logic        net_opened,
    input  wire logic        net_closed,
    input  wire logic        net_probe_ack,
    output logic             net_probe_req,
    input  wire logic        net_incoming,
    output logic             net_accept,
    output logic             net_reject,
    output logic             net_tx_valid,
    output logic      [7:0]  net_tx_data,
    input  wire logic        net_rx_valid,
    output logic             connected
);
    rx_buf_if #(.AW(AW)) buf_bus ();
    rx_buf #(.AW(AW)) u_buf (.hclk(hclk), .hresetn(hresetn), .bus(buf_bus));
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic [4:0]  ctrl_q;
    logic [15:0] lport_q, keep_q, idle_q, ndly_q;
    logic [12:0] blim_q;
    logic [7:0]  cchar_q;
    logic [31:0] dest_q;
    logic        dest_valid_q;
    logic        save_q;
    logic        wr_ph_q;
    logic [7:0]  wa_q;
    logic [31:0] hrdata_q;
    conn_state_e st_q;
    logic        auto_arm_q;

    // bus slave: zero wait states, always OKAY, unmapped reads zero
    assign hrdata    = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_ph_q   <= 1'b0;
            wa_q      <= '0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready) begin
                wr_ph_q <= hsel && (htrans == HTRANS_NONSEQ) && hwrite;
                wa_q    <= haddr;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q       <= '0;
            lport_q      <= LOCAL_PORT_RST;
            blim_q       <= BUF_LIMIT_RST;
            keep_q       <= KEEPALIVE_RST;
            idle_q       <= IDLE_TMO_RST;
            cchar_q      <= CLOSE_CHAR_RST;
            ndly_q       <= NET_DELAY_RST;
            dest_q       <= HOST_CLEAR;
            dest_valid_q <= 1'b0;
            save_q       <= 1'b0;
            auto_arm_q   <= 1'b1;
        end else begin
            save_q <= 1'b0;
            // a save re-arms auto connect; rewriting the control word disarms it
            if (save_q) begin
                auto_arm_q <= 1'b1;
            end else if (wr_ph_q && (wa_q == ADDR_CTRL)) begin
                auto_arm_q <= 1'b0;
            end
            if (wr_ph_q) begin
                if (wa_q == ADDR_CTRL) begin
                    ctrl_q <= hwdata[4:0];
                end else if (wa_q == ADDR_LPORT) begin
                    lport_q <= hwdata[15:0];
                end else if (wa_q == ADDR_BUFLIM) begin
                    // limit can only be lowered below the physical size
                    blim_q <= (hwdata[12:0] > BUF_LIMIT_RST) ? BUF_LIMIT_RST
                                                             : hwdata[12:0];
                end else if (wa_q == ADDR_KEEPALIVE) begin
                    keep_q <= hwdata[15:0];
                end else if (wa_q == ADDR_IDLE) begin
                    idle_q <= hwdata[15:0];
                end else if (wa_q == ADDR_CLOSECH) begin
                    cchar_q <= hwdata[7:0];
                end else if (wa_q == ADDR_NETDLY) begin
                    ndly_q <= hwdata[15:0];
                end else if (wa_q == ADDR_DEST) begin
                    dest_q       <= hwdata;
                    dest_valid_q <= (hwdata != HOST_CLEAR);
                end else if (wa_q == ADDR_CMD) begin
                    save_q <= hwdata[CMD_SAVE];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= '0;
        end else if (hready && hsel && (htrans == HTRANS_NONSEQ) && !hwrite) begin
            if (haddr == ADDR_CTRL) hrdata_q <= {27'h0, ctrl_q};
            else if (haddr == ADDR_STATUS)
                hrdata_q <= {16'h0, buf_bus.count, connected, 2'h0};
            else if (haddr == ADDR_LPORT) hrdata_q <= {16'h0, lport_q};
            else if (haddr == ADDR_BUFLIM) hrdata_q <= {19'h0, blim_q};
            else if (haddr == ADDR_KEEPALIVE) hrdata_q <= {16'h0, keep_q};
            else if (haddr == ADDR_IDLE) hrdata_q <= {16'h0, idle_q};
            else if (haddr == ADDR_CLOSECH) hrdata_q <= {24'h0, cchar_q};
            else if (haddr == ADDR_NETDLY) hrdata_q <= {16'h0, ndly_q};
            else if (haddr == ADDR_DEST) hrdata_q <= dest_q;
            else hrdata_q <= '0;
        end
    end

    // one-second tick prescaler
    logic [31:0] pre_q;
    logic        tick_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q  <= '0;
            tick_q <= 1'b0;
        end else if (pre_q == 32'(TICK_DIV - 1)) begin
            pre_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            pre_q  <= pre_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    logic hs_lvl, is_close, traffic, any_rx;
    assign hs_lvl   = ctrl_q[CTL_HS_DSR] ? dsr_in : cts_in;
    assign is_close = ser_rx_valid && (cchar_q != CLOSE_CHAR_RST)
                      && (ser_rx_data == cchar_q);
    assign traffic  = ser_rx_valid || ser_tx_valid || net_rx_valid;
    assign any_rx   = ser_rx_valid && !is_close;

    // idle and keep-alive second counters
    logic [15:0] idle_cnt_q, keep_cnt_q, probe_cnt_q;
    logic        conn_act;
    assign conn_act = (st_q == ST_CONN);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_cnt_q <= '0;
            keep_cnt_q <= '0;
        end else if (!conn_act || traffic) begin
            idle_cnt_q <= '0;
            keep_cnt_q <= '0;
        end else if (tick_q) begin
            idle_cnt_q <= idle_cnt_q + 16'h1;
            keep_cnt_q <= keep_cnt_q + 16'h1;
        end
    end
    logic idle_exp, keep_exp, hs_open, hs_drop;
    assign idle_exp = (idle_q != 16'h0) && (idle_cnt_q >= idle_q);
    assign keep_exp = (keep_q != 16'h0) && (keep_cnt_q >= keep_q);
    assign hs_open  = ctrl_q[CTL_HS_EN] && hs_lvl;
    assign hs_drop  = ctrl_q[CTL_HS_EN] && !hs_lvl;

    // network transmit pacing
    logic [15:0] dly_cnt_q;
    logic        send_ok;
    assign send_ok = (ndly_q == 16'h0) || (dly_cnt_q >= ndly_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q          <= ST_IDLE;
            net_open_req  <= 1'b0;
            net_close_req <= 1'b0;
            net_reset_req <= 1'b0;
            net_probe_req <= 1'b0;
            net_accept    <= 1'b0;
            net_reject    <= 1'b0;
            probe_cnt_q   <= '0;
        end else begin
            net_open_req  <= 1'b0;
            net_close_req <= 1'b0;
            net_reset_req <= 1'b0;
            net_probe_req <= 1'b0;
            net_accept    <= 1'b0;
            net_reject    <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (net_incoming) begin
                        net_accept <= 1'b1;
                        st_q       <= ST_SERVE;
                    end else if (ctrl_q[CTL_CLIENT] && dest_valid_q &&
                                 ((ctrl_q[CTL_AUTO] && auto_arm_q && !ctrl_q[CTL_HS_EN])
                                  || hs_open
                                  || (!ctrl_q[CTL_HS_EN] && any_rx))) begin
                        net_open_req <= 1'b1;
                        st_q         <= ST_OPEN;
                    end
                end
                ST_OPEN: begin
                    if (net_incoming) net_reject <= 1'b1;
                    if (net_opened) st_q <= ST_CONN;
                    else if (net_closed) st_q <= ST_IDLE;
                end
                ST_CONN: begin
                    if (net_incoming) net_reject <= 1'b1;
                    if (net_closed) begin
                        st_q <= ST_IDLE;
                    end else if (is_close || idle_exp || hs_drop) begin
                        net_close_req <= 1'b1;
                        st_q          <= ST_IDLE;
                    end else if (keep_exp) begin
                        net_probe_req <= 1'b1;
                        probe_cnt_q   <= '0;
                        st_q          <= ST_PROBE;
                    end
                end
                ST_PROBE: begin
                    if (net_incoming) net_reject <= 1'b1;
                    if (net_probe_ack || traffic) begin
                        st_q <= ST_CONN;
                    end else if (probe_cnt_q >= PROBE_WAIT_S) begin
                        net_reset_req <= 1'b1;
                        st_q          <= ST_IDLE;
                    end else if (tick_q) begin
                        probe_cnt_q <= probe_cnt_q + 16'h1;
                    end
                end
                ST_SERVE: begin
                    if (net_incoming) net_reject <= 1'b1;
                    if (net_closed) st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    a_close_char: assert property (conn_act && is_close && !net_closed |=> net_close_req)
        else $error("close character left the connection open");
    a_hs_drop: assert property (conn_act && hs_drop && !net_closed |=> net_close_req)
        else $error("dropped handshake line left the connection open");
    a_keep_probe: assert property (conn_act && keep_exp && !net_closed && !is_close
        && !idle_exp && !hs_drop |=> net_probe_req)
        else $error("keep-alive interval passed without a probe");
    a_probe_reset: assert property ((st_q == ST_PROBE) && !net_probe_ack && !traffic
        && (probe_cnt_q >= PROBE_WAIT_S) |=> net_reset_req)
        else $error("unanswered probe did not reset the connection");
    a_one_client: assert property ((st_q == ST_SERVE) && net_incoming |=> net_reject)
        else $error("second client was not rejected");

    // buffer write, flush on connect, drain to network
    logic opened_now, draining, rd_pend_q;
    assign opened_now = net_opened && (st_q == ST_OPEN) ||
                        net_incoming && (st_q == ST_IDLE);
    assign draining   = (st_q == ST_CONN || st_q == ST_SERVE) && send_ok &&
                        (buf_bus.count != '0) && !rd_pend_q;
    assign buf_bus.wr    = any_rx;
    assign buf_bus.wdata = ser_rx_data;
    assign buf_bus.flush = opened_now && ctrl_q[CTL_FLUSH];
    assign buf_bus.rd    = draining;
    assign buf_bus.limit = blim_q[AW:0];
    a_flush_empty: assert property (buf_bus.flush |=> (buf_bus.count == '0))
        else $error("flush on connect left data in the buffer");

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dly_cnt_q <= '0;
        end else if (!ser_rx_valid && buf_bus.count != '0) begin
            if (dly_cnt_q != 16'hffff) dly_cnt_q <= dly_cnt_q + 16'h1;
        end else begin
            dly_cnt_q <= '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_q    <= 1'b0;
            net_tx_valid <= 1'b0;
            connected    <= 1'b0;
        end else begin
            rd_pend_q    <= draining;
            net_tx_valid <= rd_pend_q;
            connected    <= (st_q == ST_CONN) || (st_q == ST_PROBE) ||
                            (st_q == ST_SERVE);
        end
    end
    assign net_tx_data = buf_bus.rdata;
endmodule // conn_ctrl

/* File: rtl/conn_ctrl_pkg.sv */
// constants, register map and types for the serial link connection controller
package conn_ctrl_pkg;
    localparam int          CLK_HZ          = 25_000_000;
    localparam int          TICK_S          = 1;
    localparam int          TICK_CYCLES     = CLK_HZ * TICK_S;
    localparam logic [15:0] LOCAL_PORT_RST  = 16'h1f40;
    localparam int          BUF_DEPTH       = 4096;
    localparam int          BUF_AW          = 12;
    localparam logic [12:0] BUF_LIMIT_RST   = 13'h1000;
    localparam logic [15:0] KEEPALIVE_RST   = 16'h001e;
    localparam logic [15:0] IDLE_TMO_RST    = 16'h001e;
    localparam logic [7:0]  CLOSE_CHAR_RST  = 8'h00;
    localparam logic [15:0] NET_DELAY_RST   = 16'h0000;
    localparam logic [31:0] HOST_CLEAR      = 32'h0000_0000;
    localparam logic [15:0] PROBE_WAIT_S    = 16'h0005;
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_STATUS     = 8'h04;
    localparam logic [7:0]  ADDR_LPORT      = 8'h08;
    localparam logic [7:0]  ADDR_BUFLIM     = 8'h0c;
    localparam logic [7:0]  ADDR_KEEPALIVE  = 8'h10;
    localparam logic [7:0]  ADDR_IDLE       = 8'h14;
    localparam logic [7:0]  ADDR_CLOSECH    = 8'h18;
    localparam logic [7:0]  ADDR_NETDLY     = 8'h1c;
    localparam logic [7:0]  ADDR_DEST       = 8'h20;
    localparam logic [7:0]  ADDR_CMD        = 8'h24;
    localparam int CTL_FLUSH  = 0;
    localparam int CTL_AUTO   = 1;
    localparam int CTL_HS_EN  = 2;
    localparam int CTL_HS_DSR = 3;
    localparam int CTL_CLIENT = 4;
    localparam int CMD_SAVE   = 0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    typedef enum {ST_IDLE, ST_OPEN, ST_CONN, ST_PROBE, ST_SERVE} conn_state_e;
endpackage

/* File: rtl/rx_buf_if.sv */
// interface between controller and serial receive buffer
`timescale 1ns/1ns
interface rx_buf_if #(parameter int AW = 12);
    logic          wr;
    logic [7:0]    wdata;
    logic          rd;
    logic [7:0]    rdata;
    logic [AW:0]   count;
    logic          flush;
    logic [AW:0]   limit;
    modport ctrl (output wr, wdata, rd, flush, limit, input rdata, count);
    modport mem  (input wr, wdata, rd, flush, limit, output rdata, count);
endinterface

/* File: rtl/rx_buf.sv */
// serial receive buffer memory with registered read data
`timescale 1ns/1ns
module rx_buf #(
    parameter int AW = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    rx_buf_if.mem    bus
);
    logic [7:0]  mem_q [2**AW];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic [7:0]    rdata_q;
    logic          do_wr;
    logic          do_rd;

    // a write beyond the usable limit is dropped: the serial side overruns
    assign do_wr = bus.wr && (cnt_q < bus.limit) && !bus.flush;
    assign do_rd = bus.rd && (cnt_q != '0) && !bus.flush;
    assign bus.count = cnt_q;
    assign bus.rdata = rdata_q;

    always_ff @(posedge hclk) begin
        if (do_wr) begin
            mem_q[wp_q] <= bus.wdata;
        end
    end
    always_ff @(posedge hclk) begin
        if (do_rd) begin
            rdata_q <= mem_q[rp_q];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (bus.flush) begin
            rp_q  <= wp_q;
            cnt_q <= '0;
        end else begin
            if (do_wr) wp_q <= wp_q + 1'b1;
            if (do_rd) rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
        end
    end
endmodule // rx_buf

/* File: test/net_peer.sv */
// behavioural model of the network stack and the remote server
`timescale 1ns/1ns
module net_peer (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // requests from the controller
    input  wire logic open_req,
    input  wire logic close_req,
    input  wire logic probe_req,
    // bench controls
    input  wire logic slow,
    input  wire logic ack_en,
    input  wire logic drop,
    // answers, one-cycle pulses
    output logic      opened,
    output logic      closed,
    output logic      probe_ack
);
    logic [3:0] wait_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_q    <= 4'h0;
            opened    <= 1'b0;
            closed    <= 1'b0;
            probe_ack <= 1'b0;
        end else begin
            // a slow server takes six cycles to accept
            wait_q    <= open_req ? (slow ? 4'h6 : 4'h1) : (wait_q - 4'(wait_q != 4'h0));
            opened    <= (wait_q == 4'h1);
            closed    <= close_req | drop;
            // silence stands for a broken path
            probe_ack <= probe_req & ack_en;
        end
    end
endmodule // net_peer

/* File: test/test_serial_link_connection_control.sv */
// self-checking bench for the connection controller
`timescale 1ns/1ns
module test_serial_link_connection_control;
    import conn_ctrl_pkg::*;
    localparam int DIV = 10;
    logic        hclk, hresetn, hsel, hwrite, hready, ser_rx_valid, ser_tx_valid;
    logic        cts_in, dsr_in, net_incoming, net_rx_valid, slow, ack_en, drop, rd_ph;
    logic        net_open_req, net_close_req, net_reset_req, net_probe_req, hresp;
    logic        net_opened, net_closed, net_probe_ack, net_accept, net_reject;
    logic        net_tx_valid, connected, hreadyout;
    logic [7:0]  haddr, ser_rx_data, net_tx_data, rb;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic [5:0]  ev;
    logic [31:0] rd_q[$];
    logic [7:0]  tx_q[$];
    logic [5:0]  ev_q[$];
    int          failures, num_checks, seed;
    assign hready = hreadyout;

    conn_ctrl #(.TICK_DIV(DIV), .AW(BUF_AW)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data),
        .ser_tx_valid(ser_tx_valid), .cts_in(cts_in), .dsr_in(dsr_in),
        .net_open_req(net_open_req), .net_close_req(net_close_req),
        .net_reset_req(net_reset_req), .net_opened(net_opened), .net_closed(net_closed),
        .net_probe_ack(net_probe_ack), .net_probe_req(net_probe_req),
        .net_incoming(net_incoming), .net_accept(net_accept), .net_reject(net_reject),
        .net_tx_valid(net_tx_valid), .net_tx_data(net_tx_data),
        .net_rx_valid(net_rx_valid), .connected(connected));

    net_peer peer (
        .hclk(hclk), .hresetn(hresetn), .open_req(net_open_req),
        .close_req(net_close_req), .probe_req(net_probe_req), .slow(slow),
        .ack_en(ack_en), .drop(drop), .opened(net_opened), .closed(net_closed),
        .probe_ack(net_probe_ack));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic report_and_stop;
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // single transfer: hold the address phase, then the data phase, until hready
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr  <= a;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask

    task automatic ser(input logic [7:0] b, input logic fwd);
        ser_rx_valid <= 1'b1;
        ser_rx_data  <= b;
        slow         <= 1'($random(seed));
        if (fwd) tx_q.push_back(b);
        @(posedge hclk);
        ser_rx_valid <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask

    task automatic wcon(input logic v);
        for (int i = 0; i < 400 && connected !== v; i++) @(posedge hclk);
        cmp("connected", {31'h0, v}, {31'h0, connected});
    endtask

    task automatic incoming;
        net_incoming <= 1'b1;
        @(posedge hclk);
        net_incoming <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask

    // the second process: results are matched against the oldest note
    always @(posedge hclk) begin
        if (hresetn === 1'b1) begin
            if (rd_ph) cmp("hrdata", rd_q.size() ? rd_q.pop_front() : 32'hdead_beef, hrdata);
            if (rd_ph) cmp("hreadyout/hresp", 32'h2, {30'h0, hreadyout, hresp});
            ev = {net_probe_req, net_reject, net_accept, net_reset_req, net_close_req,
                  net_open_req};
            if (net_tx_valid !== 1'b0)
                cmp("net_tx_data", tx_q.size() ? tx_q.pop_front() : 32'hdead_beef,
                    {24'h0, net_tx_data});
            if (ev !== 6'h00)
                cmp("net event", ev_q.size() ? ev_q.pop_front() : 32'hdead_beef, {26'h0, ev});
        end
        rd_ph = hsel && htrans == HTRANS_NONSEQ && !hwrite && hready;
    end

    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        report_and_stop();
    end

    initial begin
        {hsel, hwrite, ser_rx_valid, ser_tx_valid, cts_in, dsr_in} = 6'h00;
        {net_incoming, net_rx_valid, slow, ack_en, drop} = 5'h00;
        {haddr, ser_rx_data, htrans, hwdata} = 50'h0;
        hsize = 3'b010;
        hresetn = 1'b0;
        failures = 0;
        num_checks = 0;
        seed = 74307;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(ADDR_LPORT, 32'h1f40);
        rd(ADDR_BUFLIM, 32'h1000);
        rd(ADDR_KEEPALIVE, 32'h1e);
        rd(ADDR_IDLE, 32'h1e);
        rd(ADDR_CLOSECH, 32'h0);
        rd(ADDR_NETDLY, 32'h0);
        rd(8'h3c, 32'h0);
        ahb(1'b1, ADDR_BUFLIM, 32'h800);
        rd(ADDR_BUFLIM, 32'h800);
        ahb(1'b1, ADDR_KEEPALIVE, 32'hffff);
        ahb(1'b1, ADDR_IDLE, 32'h2);
        ahb(1'b1, ADDR_CTRL, 32'h1 << CTL_CLIENT);
        // buffered byte waits for a destination, then leaves ahead of the trigger
        rb = 8'h40 | 8'($random(seed));
        ser(rb, 1'b1);
        rd(ADDR_STATUS, 32'h8);
        ahb(1'b1, ADDR_DEST, 32'h0a00_0001);
        ahb(1'b1, ADDR_CMD, 32'h1 << CMD_SAVE);
        ev_q.push_back(6'h01);
        ser(8'h40 | 8'($random(seed)), 1'b1);
        wcon(1'b1);
        for (int i = 0; i < 6; i++) begin
            net_rx_valid <= i[0];
            ser_tx_valid <= !i[0];
            @(posedge hclk);
            {net_rx_valid, ser_tx_valid} <= 2'b00;
            repeat (8) @(posedge hclk);
        end
        cmp("connected", 32'h1, {31'h0, connected});
        ev_q.push_back(6'h02);
        wcon(1'b0);
        ahb(1'b1, ADDR_CLOSECH, 32'h0d);
        ev_q.push_back(6'h01);
        ser(8'h40 | 8'($random(seed)), 1'b1);
        wcon(1'b1);
        ev_q.push_back(6'h02);
        ser(8'h0d, 1'b0);
        wcon(1'b0);
        ahb(1'b1, ADDR_CTRL, (32'h1 << CTL_CLIENT) | (32'h1 << CTL_FLUSH));
        ahb(1'b1, ADDR_DEST, {HOST_CLEAR});
        rd(ADDR_DEST, 32'h0);
        ser(8'h40 | 8'($random(seed)), 1'b0);
        ahb(1'b1, ADDR_DEST, 32'h0a00_0002);
        ahb(1'b1, ADDR_IDLE, 32'h0);
        ev_q.push_back(6'h01);
        ser(8'h40 | 8'($random(seed)), 1'b0);
        wcon(1'b1);
        ser(8'h40 | 8'($random(seed)), 1'b1);
        repeat (100) @(posedge hclk);
        cmp("connected", 32'h1, {31'h0, connected});
        rd(ADDR_STATUS, 32'h4);
        ev_q.push_back(6'h20);
        ev_q.push_back(6'h04);
        ahb(1'b1, ADDR_KEEPALIVE, 32'h1);
        wcon(1'b0);
        ahb(1'b1, ADDR_KEEPALIVE, 32'hffff);
        ahb(1'b1, ADDR_CLOSECH, 32'h0);
        for (int i = 0; i < 2; i++) begin
            ahb(1'b1, ADDR_CTRL, (32'h1 << CTL_CLIENT) | (32'h1 << CTL_HS_EN) | (i << CTL_HS_DSR));
            ev_q.push_back(6'h01);
            {dsr_in, cts_in} <= 2'b01 << i;
            wcon(1'b1);
            ev_q.push_back(6'h02);
            {dsr_in, cts_in} <= 2'b00;
            wcon(1'b0);
        end
        ev_q.push_back(6'h01);
        ahb(1'b1, ADDR_CTRL, (32'h1 << CTL_CLIENT) | (32'h1 << CTL_AUTO));
        ahb(1'b1, ADDR_CMD, 32'h1 << CMD_SAVE);
        wcon(1'b1);
        ahb(1'b1, ADDR_CTRL, 32'h1 << CTL_CLIENT);
        // an answered probe keeps the link up
        ack_en <= 1'b1;
        repeat (20) @(posedge hclk);
        ev_q.push_back(6'h20);
        ahb(1'b1, ADDR_KEEPALIVE, 32'h1);
        ahb(1'b1, ADDR_KEEPALIVE, 32'hffff);
        repeat (20) @(posedge hclk);
        cmp("connected", 32'h1, {31'h0, connected});
        ev_q.push_back(6'h10);
        incoming();
        ev_q.push_back(6'h02);
        ahb(1'b1, ADDR_IDLE, 32'h2);
        wcon(1'b0);
        ev_q.push_back(6'h08);
        incoming();
        wcon(1'b1);
        ev_q.push_back(6'h10);
        incoming();
        drop <= 1'b1;
        @(posedge hclk);
        drop <= 1'b0;
        repeat (20) @(posedge hclk);
        cmp("notes left", 32'h0, rd_q.size() + tx_q.size() + ev_q.size());
        report_and_stop();
    end
endmodule // test_serial_link_connection_control
